// >>> fcas_defines.svh
// Functional notes
// (R1) While a fault is active the output shows the error level, not temperature.
// (R2) Thirteen distinct levels in 0..10 V, each mapped to code or code group.
// (R3) Codes 104-106, 111-113, 211 alternate at 1 Hz with full scale.
// (R4) Start during an alternating error freezes output at the error level.
// (R5) Reset key, reset input or power-up clears the active error.
// (R6) 101=0.66 V, 102=1.33 V, 103=2.00 V, 307-310=2.66 V, 201-203=3.33 V.
// (R7) Code 304 gives a steady 4.00 V.
// (R8) Codes in the 900 range give a steady 4.66 V.
// (R9) The receiving controller uses tolerance windows wide enough for output error.
// (R10) The receiving controller ignores levels seen while the device powers down.
// (R11) Alarm contact open for warnings, closes once start is asserted.
// (R12) Start promotes a warning to fault: steady output, alarm closed.
// (R13) Without fault, output is proportional to temperature, full scale at range maximum.
`ifndef FCAS_DEFINES_SVH
`define FCAS_DEFINES_SVH

// ----------------------------------------
// Output scale: 12-bit DAC code, 4095 = 10 V
// ----------------------------------------
`define FCAS_DAC_W        12
`define FCAS_DAC_FULL     12'hFFF
// Levels rounded down from volts * 409.5, except FCAS_LVL_5V33 at 0x883
`define FCAS_LVL_0V66     12'h10E
`define FCAS_LVL_1V33     12'h220
`define FCAS_LVL_2V00     12'h333
`define FCAS_LVL_2V66     12'h441
`define FCAS_LVL_3V33     12'h553
`define FCAS_LVL_4V00     12'h666
`define FCAS_LVL_4V66     12'h774
`define FCAS_LVL_5V33     12'h883
`define FCAS_LVL_6V00     12'h999
`define FCAS_LVL_6V66     12'hAA7
`define FCAS_LVL_7V33     12'hBB9
`define FCAS_LVL_8V00     12'hCCC
`define FCAS_LVL_8V66     12'hDDA

// ----------------------------------------
// Timing
// ----------------------------------------
`define FCAS_CLK_HZ       100000000
`define FCAS_BLINK_HZ     1
// Half period of 1 Hz blink, in clock cycles
`define FCAS_HALF_CYC     (`FCAS_CLK_HZ / (2 * `FCAS_BLINK_HZ))
`define FCAS_CODE_W       10
`define FCAS_TEMP_W       16

`endif

// >>> fcas_level_map.sv
`timescale 1ns/1ps
`include "fcas_defines.svh"
// Error code to output level and blink class
module fcas_level_map
	import fcas_pkg::*;
(
	// Code in
	input  wire logic [`FCAS_CODE_W-1:0] i_code,
	// Level out
	output logic      [`FCAS_DAC_W-1:0]  o_level,
	output logic                         o_blink
);
	// ----------------------------------------
	// Code decode
	// ----------------------------------------
	// Unlisted codes fall to the controller-fault level so nothing reads as healthy
	always_comb begin
		o_blink = 1'b0;
		o_level = `FCAS_LVL_4V66; // R8
		if (i_code == 10'd101) begin
			o_level = `FCAS_LVL_0V66; // R6
		end else if (i_code == 10'd102) begin
			o_level = `FCAS_LVL_1V33; // R6
		end else if (i_code == 10'd103) begin
			o_level = `FCAS_LVL_2V00; // R6
		end else if (i_code >= 10'd307 && i_code <= 10'd310) begin
			o_level = `FCAS_LVL_2V66; // R6
		end else if (i_code >= 10'd201 && i_code <= 10'd203) begin
			o_level = `FCAS_LVL_3V33; // R6
		end else if (i_code == 10'd304) begin
			o_level = `FCAS_LVL_4V00; // R7
		end else if (i_code >= 10'd900 && i_code <= 10'd999) begin
			o_level = `FCAS_LVL_4V66; // R8
		end else if (i_code >= 10'd104 && i_code <= 10'd106) begin
			o_level = `FCAS_LVL_5V33; // R2
			o_blink = 1'b1; // R3
		end else if (i_code == 10'd211) begin
			o_level = `FCAS_LVL_6V00; // R2
			o_blink = 1'b1; // R3
		end else if (i_code >= 10'd111 && i_code <= 10'd113) begin
			o_level = `FCAS_LVL_6V66; // R2
			o_blink = 1'b1; // R3
		end else if (i_code == 10'd107 || i_code == 10'd108) begin
			o_level = `FCAS_LVL_7V33; // R2
		end else if (i_code == 10'd302 || i_code == 10'd303) begin
			o_level = `FCAS_LVL_8V00; // R2
		end else if (i_code == 10'd801) begin
			o_level = `FCAS_LVL_8V66; // R2
		end
	end
endmodule

// >>> fcas_pkg.sv
package fcas_pkg;
	typedef enum logic [1:0] {
		FCAS_IDLE,
		FCAS_WARN,
		FCAS_FAULT
	} fcas_state_t;
endpackage

// >>> fcas_plc_model.sv
`timescale 1ns/1ps
`include "fcas_defines.svh"
// Receiving controller: decodes the analog level into a level index
module fcas_plc_model (
	// Clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_resetn,
	// Analog level
	input  wire logic [`FCAS_DAC_W-1:0]     i_dac,
	// Index 1..13 of a level, 14 full scale, 0 none
	output logic      [3:0]                 o_idx
);
	localparam logic [11:0] LVL [1:13] = '{`FCAS_LVL_0V66, `FCAS_LVL_1V33, `FCAS_LVL_2V00,
		`FCAS_LVL_2V66, `FCAS_LVL_3V33, `FCAS_LVL_4V00, `FCAS_LVL_4V66, `FCAS_LVL_5V33,
		`FCAS_LVL_6V00, `FCAS_LVL_6V66, `FCAS_LVL_7V33, `FCAS_LVL_8V00, `FCAS_LVL_8V66};
	// Window of +-0x40 absorbs output error without reaching a neighbour
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_idx <= 4'h0;
		end else begin
			o_idx <= (i_dac > 12'hFBF) ? 4'hE : 4'h0;
			for (int k = 1; k <= 13; k++) begin
				if (i_dac >= LVL[k] - 12'h40 && i_dac <= LVL[k] + 12'h40) begin
					o_idx <= k[3:0];
				end
			end
		end
	end
endmodule

// >>> fcas_signaller.sv
`timescale 1ns/1ps
`include "fcas_defines.svh"
// Fault-code signalling on the actual-value analog output
module fcas_signaller
	import fcas_pkg::*;
#(
	parameter int unsigned HALF_CYC = `FCAS_HALF_CYC
)(
	// Clock and reset
	input  wire logic                        i_clk,
	input  wire logic                        i_resetn,
	// Fault source (same clock domain)
	input  wire logic                        i_fault_pulse,
	input  wire logic [`FCAS_CODE_W-1:0]     i_fault_code,
	// Measured temperature and range maximum (same clock domain)
	input  wire logic [`FCAS_TEMP_W-1:0]     i_temp,
	input  wire logic [`FCAS_TEMP_W-1:0]     i_temp_max,
	// Pins from outside
	input  wire logic                        i_start_pin,
	input  wire logic                        i_reset_pin,
	input  wire logic                        i_reset_key,
	// Outputs
	output logic      [`FCAS_DAC_W-1:0]      o_dac,
	output logic                             o_alarm_closed,
	output logic                             o_fault_active
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] sync1;
	logic [2:0] sync2;
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else begin
			sync1 <= {i_reset_key, i_reset_pin, i_start_pin};
			sync2 <= sync1;
		end
	end
	logic start_s;
	logic clear_s;
	assign start_s = sync2[0];
	assign clear_s = sync2[1] | sync2[2];

	// ----------------------------------------
	// Latched code and its level
	// ----------------------------------------
	fcas_state_t              state;
	logic [`FCAS_CODE_W-1:0]  code;
	logic [`FCAS_DAC_W-1:0]   map_level;
	logic                     map_blink;

	fcas_level_map u_map (
		.i_code  (code),
		.o_level (map_level),
		.o_blink (map_blink)
	);

	// Code captured with the first fault; later faults do not overwrite it
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			code <= 10'h000;
		end else if (state == FCAS_IDLE && i_fault_pulse && !clear_s) begin
			code <= i_fault_code;
		end
	end

	// ----------------------------------------
	// Fault state machine
	// ----------------------------------------
	// Power-up reset starts in idle, so a power cycle clears the error
	logic new_blink;
	always_comb begin
		new_blink = (i_fault_code >= 10'd104 && i_fault_code <= 10'd106) ||
		            (i_fault_code >= 10'd111 && i_fault_code <= 10'd113) ||
		            (i_fault_code == 10'd211);
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state <= FCAS_IDLE; // R5
		end else begin
			case (state)
				FCAS_IDLE: begin
					if (i_fault_pulse && !clear_s) begin
						state <= new_blink ? FCAS_WARN : FCAS_FAULT;
					end
				end
				FCAS_WARN: begin
					if (clear_s) begin
						state <= FCAS_IDLE; // R5
					end else if (start_s) begin
						state <= FCAS_FAULT; // R4 R12
					end
				end
				FCAS_FAULT: begin
					if (clear_s) begin
						state <= FCAS_IDLE; // R5
					end
				end
				default: begin
					state <= FCAS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// 1 Hz blink timer
	// ----------------------------------------
	// Restarts on each warning so the first half shows the error level
	logic [26:0] blink_cnt;
	logic        blink_hi;
	always_ff @(posedge i_clk) begin
		if (!i_resetn || state != FCAS_WARN) begin
			blink_cnt <= 27'h0;
			blink_hi  <= 1'b0;
		end else if (blink_cnt == 27'(HALF_CYC - 1)) begin
			blink_cnt <= 27'h0;
			blink_hi  <= ~blink_hi; // R3
		end else begin
			blink_cnt <= blink_cnt + 27'h1;
		end
	end

	// ----------------------------------------
	// Temperature scaling
	// ----------------------------------------
	// Division kept combinational; fine for a slow analog output path
	logic [`FCAS_DAC_W-1:0] temp_level;
	logic [27:0]            temp_prod;
	always_comb begin
		temp_prod = 28'(i_temp) * 28'(`FCAS_DAC_FULL);
		if (i_temp_max == 16'h0 || i_temp >= i_temp_max) begin
			temp_level = `FCAS_DAC_FULL;
		end else begin
			temp_level = 12'(temp_prod / 28'(i_temp_max)); // R13
		end
	end

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_dac          <= 12'h000;
			o_alarm_closed <= 1'b0;
			o_fault_active <= 1'b0;
		end else begin
			o_fault_active <= (state != FCAS_IDLE);
			o_alarm_closed <= (state == FCAS_FAULT); // R11 R12
			case (state)
				FCAS_IDLE:  o_dac <= temp_level; // R13
				FCAS_WARN:  o_dac <= blink_hi ? `FCAS_DAC_FULL : map_level; // R3
				FCAS_FAULT: o_dac <= map_level; // R1 R4
				default:    o_dac <= temp_level;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	warn_alarm_open_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R11
		$past(state) == FCAS_WARN |-> !o_alarm_closed)
		else $error("alarm closed during warning");
	start_freezes_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
		state == FCAS_WARN && start_s && !clear_s |=> state == FCAS_FAULT)
		else $error("start did not freeze warning");
	fault_level_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
		state == FCAS_FAULT && $stable(code) |=> o_dac == $past(map_level))
		else $error("fault output not error level");
	clear_idle_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R5
		clear_s |=> state == FCAS_IDLE)
		else $error("clear did not return to idle");
	blink_toggle_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
		state == FCAS_WARN && blink_cnt == 27'(HALF_CYC - 1) && !clear_s && !start_s
		|=> blink_hi != $past(blink_hi))
		else $error("blink did not toggle");
	blink_full_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
		state == FCAS_WARN && blink_hi |=> o_dac == `FCAS_DAC_FULL)
		else $error("blink high not full scale");
	lvl_304_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R7
		code == 10'd304 |-> map_level == `FCAS_LVL_4V00)
		else $error("304 level wrong");
	lvl_900_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R8
		code == 10'd901 |-> map_level == `FCAS_LVL_4V66 && !map_blink)
		else $error("900 range level wrong");
	lvl_101_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R6
		code == 10'd101 |-> map_level == `FCAS_LVL_0V66)
		else $error("101 level wrong");
	// First edge after reset still shows the reset value, so it is skipped
	idle_temp_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R13
		$past(i_resetn) && state == FCAS_IDLE && $past(state) == FCAS_IDLE
		&& $stable(i_temp) && $stable(i_temp_max) |-> o_dac == $past(temp_level))
		else $error("idle output not temperature");
	// Latched fault raises the flag one edge later
	active_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
		state != FCAS_IDLE |=> o_fault_active)
		else $error("fault flag not raised");
	// Level source must not drift while an error is shown
	code_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R1
		state != FCAS_IDLE |=> $stable(code))
		else $error("latched code changed");
	// Alarm and freeze follow the promoted state
	fault_alarm_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R12
		state == FCAS_FAULT |=> o_alarm_closed)
		else $error("alarm open during fault");
	fault_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R4
		state == FCAS_FAULT && !clear_s |=> state == FCAS_FAULT)
		else $error("fault left without clear");
	// Low phase of the blink shows the error level itself
	warn_level_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
		state == FCAS_WARN && !blink_hi |=> o_dac == $past(map_level))
		else $error("warning low phase not error level");
	// Blink timer never runs past a half period
	blink_range_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R3
		blink_cnt < 27'(HALF_CYC))
		else $error("blink counter past half period");
	// Idle is left only by a taken fault
	idle_no_fault_a: assert property (@(posedge i_clk) disable iff (!i_resetn) // R13
		state == FCAS_IDLE && !i_fault_pulse |=> state == FCAS_IDLE)
		else $error("idle left without fault");
endmodule

// >>> fcas_signaller_tb_top.sv
`timescale 1ns/1ps
`include "fcas_defines.svh"
module fcas_signaller_tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk, resetn, fpulse, start, rpin, rkey, alarm, active;
	logic [9:0]  fcode;
	logic [15:0] temp, tmax;
	logic [11:0] dac;
	logic [3:0]  cls;
	int          bad_count, num_checks;

	fcas_signaller #(.HALF_CYC(8)) dut (.i_clk(clk), .i_resetn(resetn),
		.i_fault_pulse(fpulse), .i_fault_code(fcode), .i_temp(temp), .i_temp_max(tmax),
		.i_start_pin(start), .i_reset_pin(rpin), .i_reset_key(rkey), .o_dac(dac),
		.o_alarm_closed(alarm), .o_fault_active(active));
	fcas_plc_model plc (.i_clk(clk), .i_resetn(resetn), .i_dac(dac), .o_idx(cls));

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict;
		if (bad_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Bounded wait: s=0 level, s=1 fault flag, s=2 alarm
	task automatic wait_for(input int s, input logic [11:0] v, input int lim);
		logic [11:0] cur;
		for (int n = 0; n <= lim; n++) begin
			cur = (s == 0) ? dac : (s == 1) ? {11'h0, active} : {11'h0, alarm};
			if (cur === v) return;
			@(negedge clk);
		end
		bad_count++;
		$display("mismatch wait %0d expected %h seen %h", s, v, cur);
		give_verdict();
	endtask
	task automatic raise(input logic [9:0] c);
		@(negedge clk);
		fpulse = 1'b1;
		fcode = c;
		@(negedge clk);
		fpulse = 1'b0;
		wait_for(1, 12'h1, 10);
		@(negedge clk);
	endtask
	// Held long enough to pass the input synchronisers
	task automatic clear(input bit pin);
		if (pin) rpin = 1'b1;
		else rkey = 1'b1;
		repeat (4) @(negedge clk);
		rpin = 1'b0;
		rkey = 1'b0;
		wait_for(1, 12'h0, 10);
		@(negedge clk);
		chk("temp after clear", dac, 16'h3FF);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_temp;
		repeat (3) @(negedge clk);
		chk("temp level", dac, 16'h3FF);
		temp = 16'h00C8;
		repeat (2) @(negedge clk);
		chk("temp half", dac, 16'h7FF);
		temp = 16'h0190;
		repeat (2) @(negedge clk);
		chk("temp at max", dac, 16'hFFF);
		temp = 16'h0064;
		repeat (2) @(negedge clk);
	endtask
	task automatic t_steady;
		logic [9:0]  c [10] = '{101, 102, 103, 307, 310, 201, 203, 304, 901, 999};
		logic [11:0] l [10] = '{12'h10E, 12'h220, 12'h333, 12'h441, 12'h441,
			12'h553, 12'h553, 12'h666, 12'h774, 12'h774};
		logic [3:0]  x [10] = '{1, 2, 3, 4, 4, 5, 5, 6, 7, 7};
		for (int i = 0; i < 10; i++) begin
			raise(c[i]);
			chk("code level", dac, l[i]);
			chk("alarm", alarm, 1);
			chk("decoded", cls, x[i]);
			clear(i[0]);
		end
	endtask
	task automatic t_blink;
		logic [9:0]  c [3] = '{104, 112, 211};
		logic [11:0] l [3] = '{12'h883, 12'hAA7, 12'h999};
		for (int i = 0; i < 3; i++) begin
			raise(c[i]);
			chk("blink level", dac, l[i]);
			chk("warn alarm", alarm, 0);
			wait_for(0, 12'hFFF, 10);
			wait_for(0, l[i], 10);
			start = 1'b1;
			wait_for(2, 12'h1, 10);
			repeat (20) begin
				@(negedge clk);
				chk("frozen level", dac, l[i]);
			end
			start = 1'b0;
			clear(i[0]);
		end
	endtask
	task automatic t_power;
		raise(102);
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		chk("decode in reset", cls, 0);
		resetn = 1'b1;
		@(negedge clk);
		chk("fault after reset", active, 0);
		chk("alarm after reset", alarm, 0);
		@(negedge clk);
		chk("temp after reset", dac, 16'h3FF);
	endtask

	// Main sequence
	initial begin
		{resetn, fpulse, start, rpin, rkey} = '0;
		fcode = 10'h0;
		temp = 16'h0064;
		tmax = 16'h0190;
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		t_temp();
		t_steady();
		t_blink();
		t_power();
		give_verdict();
	end
endmodule
